// file: core/audio_port_regs.vh
`ifndef AUDIO_PORT_REGS_VH
`define AUDIO_PORT_REGS_VH

// ****************************************************************
// Register indexes; the byte address is four times the index.
// ****************************************************************
`define SETUP_INDEX 12'h524
`define FORMAT_INDEX 12'h525
`define STATUS_INDEX 12'h526
`define SETUP_RESET 32'h00000000
`define SETUP_MASK 32'h3F0F3FFF
`define FORMAT_RESET 3'h0

// ****************************************************************
// Setup word fields, and the format word's receive-width field.
// ****************************************************************
`define STEREO_BIT 0
`define RX_EN_BIT 1
`define TX_EN_BIT 2
`define BCLK_ROLE_BIT 3
`define WS_ROLE_BIT 4
`define PHASE_BIT 5
`define ORDER_BIT 6
`define POLARITY_BIT 7
`define HALF_DIV_RANGE 13:8
`define NUMER_RANGE 18:16
`define DENOM_BIT 19
`define FRAME_LEN_RANGE 26:24
`define SYNC_WIDTH_RANGE 29:27
`define RX_WIDTH_RANGE 2:0

// ****************************************************************
// Code tables, entry 0 in the low bits.
// ****************************************************************
`define MONO_LEN_TAB {7'h20, 7'h19, 7'h18, 7'h14, 7'h12, 7'h10, 7'h0C, 7'h08}
`define STEREO_LEN_TAB {7'h40, 7'h32, 7'h30, 7'h28, 7'h24, 7'h20, 7'h18, 7'h10}
`define SYNC_WIDTH_TAB {5'h10, 5'h0F, 5'h0B, 5'h08, 5'h07, 5'h04, 5'h02, 5'h01}
`define RX_WIDTH_TAB {5'h08, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h12, 5'h14, 5'h18}
`define NUMER_TAB {8'h00, 8'h30, 8'h40, 8'h48, 8'h50, 8'h60, 8'h64, 8'h00}
`define DENOM_128 8'h80
`define DENOM_125 8'h7D
`define HALF_STEP 7'h02
`define WORD_BITS 5'h18
`define FULL_WORD 24'hFFFFFF

`endif

// file: core/audio_clock_gen.v
`timescale 1ns/1ns
`include "audio_port_regs.vh"

module audio_clock_gen
(
   // Clock and reset.
   input wire clock,
   input wire rst_b,
   // Settings.
   input wire run,
   input wire [5:0] halfDivCode,
   input wire [2:0] numCode,
   input wire denSel,
   // Half-period tick of the bit clock.
   output reg tick_ff
);

   wire [7:0] den;
   wire [7:0] numTab;
   wire [63:0] numShift;
   wire [7:0] accSum;
   wire synthPulse;
   wire [6:0] halfSum;
   wire [6:0] ratio;
   reg [7:0] synthAcc_ff;
   reg [6:0] halfAcc_ff;

   // ****************************************************************
   // Fractional synthesizer: numerator pulses per denominator cycles.
   // ****************************************************************
   assign den = denSel ? `DENOM_125 : `DENOM_128;
   assign numShift = `NUMER_TAB >> {numCode, 3'h0};
   assign numTab = numShift[7:0];
   assign accSum = synthAcc_ff + numTab;
   assign synthPulse = (numCode == 3'h0) ? 1'b1 : (accSum >= den);

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         synthAcc_ff <= 8'h00;
      else if (!run)
         synthAcc_ff <= 8'h00;
      else if (numCode != 3'h0)
         synthAcc_ff <= synthPulse ? accSum - den : accSum;
   end

   // ****************************************************************
   // Half-cycle divider: ratio (code+1)/2, counted in half steps.
   // ****************************************************************
   assign ratio = {1'b0, halfDivCode} + 7'h01;
   assign halfSum = halfAcc_ff + `HALF_STEP;

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         halfAcc_ff <= 7'h00;
         tick_ff <= 1'b0;
      end
      else if (!run)
      begin
         halfAcc_ff <= 7'h00;
         tick_ff <= 1'b0;
      end
      else if (halfDivCode == 6'h00)
      begin
         halfAcc_ff <= 7'h00;
         tick_ff <= synthPulse;
      end
      else if (synthPulse && halfSum >= ratio)
      begin
         halfAcc_ff <= halfSum - ratio;
         tick_ff <= 1'b1;
      end
      else
      begin
         if (synthPulse)
            halfAcc_ff <= halfSum;
         tick_ff <= 1'b0;
      end
   end

endmodule // audio_clock_gen

// file: core/serial_audio_port_config.v
// Overview of operation
// - Bit-clock role 1: device drives bit clock while receive or transmit enabled.
// - Word-select role 1: device drives word select while receive or transmit enabled.
// - Phase 0: transmit on falling edge, sample on rising edge.
// - Phase 1: transmit on rising edge, sample on falling edge.
// - Order 0: stereo frame carries left then right.
// - Order 1: stereo frame carries right then left.
// - Mono: rising sync edge starts a data word.
// - Polarity 0: sync low is left, high is right.
// - Polarity 1: sync low is right, high is left.
// - Six-bit half-cycle divider, code zero bypasses, ratio (code+1)/2.
// - Synthesizer numerator table per code; code zero equals denominator.
// - Denominator bit picks 128 or 125 for the synthesizer.
// - Frame-length code sets bit clocks per frame, mono and stereo tables.
// - Mono sync pulse width in bit clocks from code table.
// - Receive-width code sets valid received bits per word.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`include "audio_port_regs.vh"

module serial_audio_port_config
(
   // Clock and reset.
   input wire clock,
   input wire rst_b,
   // Avalon-MM slave, byte address.
   input wire [13:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   // Serial link pins.
   input wire sclkIn,
   output reg sclkOut,
   output reg sclkOe_b,
   input wire wsIn,
   output reg wsOut,
   output reg wsOe_b,
   input wire sdIn,
   output reg sdOut,
   output reg sdOe_b,
   // Audio samples.
   input wire [23:0] txLeft,
   input wire [23:0] txRight,
   output reg txLoad,
   output reg [23:0] rxLeft,
   output reg [23:0] rxRight,
   output reg rxValid,
   output reg rxIsRight
);

   reg [31:0] setup_ff;
   reg [2:0] format_ff;
   reg [2:0] sclkSync_ff;
   reg [1:0] wsSync_ff;
   reg [1:0] sdSync_ff;
   reg wsPrev_ff;
   reg bitClk_ff;
   reg [6:0] bitCnt_ff;
   reg [23:0] txLeftHold_ff;
   reg [23:0] txRightHold_ff;
   reg [23:0] rxShift_ff;
   reg [31:0] nxt_readdata;

   wire [11:0] wordIndex;
   wire stereo;
   wire rxEn;
   wire txEn;
   wire clkMaster;
   wire wsMaster;
   wire phase;
   wire order;
   wire polarity;
   wire run;
   wire tick;
   wire [6:0] frameLen;
   wire [6:0] halfLen;
   wire [4:0] syncWidth;
   wire [4:0] rxWidth;
   wire sclkRise;
   wire sclkFall;
   wire bitRise;
   wire bitFall;
   wire sampleEv;
   wire launchEv;
   wire firstLevel;
   wire slaveStart;
   wire [6:0] slotNext;
   wire [6:0] rxSlot;
   wire [6:0] txSlot;
   wire [6:0] rxChanSlot;
   wire [6:0] txChanSlot;
   wire rxSecond;
   wire txSecond;
   wire rxRightCh;
   wire txRightCh;
   wire [23:0] txWord;
   wire [23:0] rxMask;
   wire [4:0] txBitIdx;
   wire [4:0] rxBitIdx;
   wire wsLevel;
   wire [55:0] monoLenSel;
   wire [55:0] stereoLenSel;
   wire [39:0] syncWidthSel;
   wire [39:0] rxWidthSel;

   // ****************************************************************
   // Register bus.
   // ****************************************************************
   assign wordIndex = address[13:2];

   always @*
   begin
      nxt_readdata = 32'h00000000;
      if (wordIndex == `SETUP_INDEX)
         nxt_readdata = setup_ff;
      else if (wordIndex == `FORMAT_INDEX)
         nxt_readdata = {29'h0, format_ff};
      else if (wordIndex == `STATUS_INDEX)
         nxt_readdata = {16'h0, 1'b0, bitCnt_ff, 6'h00, bitClk_ff, rxIsRight};
   end

   // The answer comes one cycle after the request is seen, so a request
   // always meets waitrequest high at its first edge.
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
         setup_ff <= `SETUP_RESET;
         format_ff <= `FORMAT_RESET;
      end
      else if (waitrequest && (read || write))
      begin
         waitrequest <= 1'b0;
         readdata <= nxt_readdata;
      end
      else
      begin
         waitrequest <= 1'b1;
         if (!waitrequest && write && wordIndex == `SETUP_INDEX)
            setup_ff <= writedata & `SETUP_MASK;
         if (!waitrequest && write && wordIndex == `FORMAT_INDEX)
            format_ff <= writedata[`RX_WIDTH_RANGE];
      end
   end

   // ****************************************************************
   // Field decode.
   // ****************************************************************
   assign stereo = setup_ff[`STEREO_BIT];
   assign rxEn = setup_ff[`RX_EN_BIT];
   assign txEn = setup_ff[`TX_EN_BIT];
   assign clkMaster = setup_ff[`BCLK_ROLE_BIT];
   assign wsMaster = setup_ff[`WS_ROLE_BIT];
   assign phase = setup_ff[`PHASE_BIT];
   assign order = setup_ff[`ORDER_BIT];
   assign polarity = setup_ff[`POLARITY_BIT];
   assign run = rxEn | txEn;
   assign stereoLenSel = `STEREO_LEN_TAB >> (7 * setup_ff[`FRAME_LEN_RANGE]);
   assign monoLenSel = `MONO_LEN_TAB >> (7 * setup_ff[`FRAME_LEN_RANGE]);
   assign frameLen = stereo ? stereoLenSel[6:0] : monoLenSel[6:0];
   assign halfLen = stereo ? {1'b0, frameLen[6:1]} : frameLen;
   assign syncWidthSel = `SYNC_WIDTH_TAB >> (5 * setup_ff[`SYNC_WIDTH_RANGE]);
   assign syncWidth = syncWidthSel[4:0];
   assign rxWidthSel = `RX_WIDTH_TAB >> (5 * format_ff);
   assign rxWidth = rxWidthSel[4:0];

   // ****************************************************************
   // Clock generation and pin synchronisers.
   // ****************************************************************
   audio_clock_gen i_audio_clock_gen
   (
      .clock(clock),
      .rst_b(rst_b),
      .run(run & clkMaster),
      .halfDivCode(setup_ff[`HALF_DIV_RANGE]),
      .numCode(setup_ff[`NUMER_RANGE]),
      .denSel(setup_ff[`DENOM_BIT]),
      .tick_ff(tick)
   );

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclkSync_ff <= 3'h0;
         wsSync_ff <= 2'h0;
         sdSync_ff <= 2'h0;
         bitClk_ff <= 1'b0;
      end
      else
      begin
         sclkSync_ff <= {sclkSync_ff[1:0], sclkIn};
         wsSync_ff <= {wsSync_ff[0], wsIn};
         sdSync_ff <= {sdSync_ff[0], sdIn};
         if (!(run && clkMaster))
            bitClk_ff <= 1'b0;
         else if (tick)
            bitClk_ff <= ~bitClk_ff;
      end
   end

   // An internal bit clock faster than a few system cycles per half period
   // cannot be met by the two-stage input path; keep the divide ratio sane.
   assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
   assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2];
   assign bitRise = clkMaster ? (run & tick & ~bitClk_ff) : sclkRise;
   assign bitFall = clkMaster ? (run & tick & bitClk_ff) : sclkFall;
   assign sampleEv = run & (phase ? bitFall : bitRise);
   assign launchEv = run & (phase ? bitRise : bitFall);

   // ****************************************************************
   // Frame position.
   // ****************************************************************
   // Master word select: the counter names the slot being driven. Slave
   // word select: the counter names the next slot expected on the line.
   assign firstLevel = order ^ polarity;
   assign slaveStart = stereo ?
      (wsSync_ff[1] == firstLevel && wsPrev_ff != firstLevel) :
      (wsSync_ff[1] && !wsPrev_ff);
   assign slotNext = (bitCnt_ff >= frameLen - 7'h01) ? 7'h00 : bitCnt_ff + 7'h01;
   assign rxSlot = (!wsMaster && slaveStart) ? 7'h00 : bitCnt_ff;
   assign txSlot = wsMaster ? slotNext : bitCnt_ff;
   assign rxSecond = stereo && rxSlot >= halfLen;
   assign txSecond = stereo && txSlot >= halfLen;
   assign rxChanSlot = rxSecond ? rxSlot - halfLen : rxSlot;
   assign txChanSlot = txSecond ? txSlot - halfLen : txSlot;
   assign rxRightCh = stereo & (rxSecond ^ order);
   assign txRightCh = stereo & (txSecond ^ order);
   assign wsLevel = stereo ? (txRightCh ^ polarity) :
      ({2'h0, txSlot} < {2'h0, syncWidth});

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bitCnt_ff <= 7'h00;
         wsPrev_ff <= 1'b0;
      end
      else if (!run)
      begin
         bitCnt_ff <= 7'h00;
         wsPrev_ff <= 1'b0;
      end
      else if (wsMaster)
      begin
         if (launchEv)
            bitCnt_ff <= slotNext;
      end
      else if (sampleEv)
      begin
         wsPrev_ff <= wsSync_ff[1];
         bitCnt_ff <= slaveStart ? 7'h01 : slotNext;
      end
   end

   // ****************************************************************
   // Transmit path.
   // ****************************************************************
   assign txWord = txRightCh ? txRightHold_ff : txLeftHold_ff;
   assign txBitIdx = 5'h17 - txChanSlot[4:0];

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         txLeftHold_ff <= 24'h000000;
         txRightHold_ff <= 24'h000000;
         txLoad <= 1'b0;
         sdOut <= 1'b0;
         sdOe_b <= 1'b1;
         sclkOut <= 1'b0;
         sclkOe_b <= 1'b1;
         wsOut <= 1'b0;
         wsOe_b <= 1'b1;
      end
      else
      begin
         txLoad <= 1'b0;
         sdOe_b <= ~txEn;
         // The pin takes the bit clock's next value, so clock and data leave together.
         sclkOut <= (run && clkMaster) ? (bitClk_ff ^ tick) : 1'b0;
         sclkOe_b <= ~(clkMaster & run);
         wsOe_b <= ~(wsMaster & run);
         if (!txEn)
            sdOut <= 1'b0;
         if (wsMaster && launchEv)
            wsOut <= wsLevel;
         if (txEn && launchEv)
         begin
            if (txSlot == 7'h00)
            begin
               txLeftHold_ff <= txLeft;
               txRightHold_ff <= txRight;
               txLoad <= 1'b1;
               sdOut <= (order && stereo) ? txRight[23] : txLeft[23];
            end
            else if (txChanSlot < {2'h0, `WORD_BITS})
               sdOut <= txWord[txBitIdx];
            else
               sdOut <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Receive path.
   // ****************************************************************
   assign rxBitIdx = 5'h17 - rxChanSlot[4:0];
   assign rxMask = `FULL_WORD << (`WORD_BITS - rxWidth);

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rxShift_ff <= 24'h000000;
         rxLeft <= 24'h000000;
         rxRight <= 24'h000000;
         rxValid <= 1'b0;
         rxIsRight <= 1'b0;
      end
      else
      begin
         rxValid <= 1'b0;
         if (rxEn && sampleEv)
         begin
            if (rxChanSlot == 7'h00)
               rxShift_ff <= {sdSync_ff[1], 23'h000000};
            else if (rxChanSlot < {2'h0, `WORD_BITS})
               rxShift_ff[rxBitIdx] <= sdSync_ff[1];
            if (rxChanSlot == halfLen - 7'h01)
            begin
               rxValid <= 1'b1;
               rxIsRight <= rxRightCh;
               if (rxRightCh)
                  rxRight <= rxShift_ff & rxMask;
               else
                  rxLeft <= rxShift_ff & rxMask;
            end
         end
      end
   end

endmodule // serial_audio_port_config

// file: test/serial_audio_port_properties.sv
`timescale 1ns/1ns
// ********
// Link and bus checks.
// ********
module serial_audio_port_checker
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Bus.
   input wire logic [13:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   // Link and samples.
   input wire logic sclkOut,
   input wire logic sclkOe_b,
   input wire logic wsOut,
   input wire logic wsOe_b,
   input wire logic sdOut,
   input wire logic sdOe_b,
   input wire logic txLoad,
   input wire logic rxValid
);
   // The setup word is shadowed from bus writes, as the register itself is out of view.
   logic [31:0] cfg_ff;
   logic [3:0] quiet_ff;
   logic [6:0] rises_ff;
   logic loaded_ff;
   logic lastClk_ff;
   wire on = cfg_ff[1] | cfg_ff[2];
   wire settled = quiet_ff == 4'hF;
   wire rise = sclkOut & ~lastClk_ff;
   int lenTab[16] = '{8, 12, 16, 18, 20, 24, 25, 32, 16, 24, 32, 36, 40, 48, 50, 64};

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_ff <= 32'h0;
         quiet_ff <= 4'h0;
         rises_ff <= 7'h0;
         loaded_ff <= 1'b0;
         lastClk_ff <= 1'b0;
      end
      else
      begin
         lastClk_ff <= sclkOut;
         rises_ff <= (txLoad ? 7'h0 : rises_ff) + {6'h0, rise};
         if (write && !waitrequest && address == 14'h1490)
         begin
            cfg_ff <= writedata;
            quiet_ff <= 4'h0;
            loaded_ff <= 1'b0;
         end
         else
         begin
            quiet_ff <= quiet_ff + {3'h0, quiet_ff != 4'hF};
            loaded_ff <= loaded_ff | txLoad;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered in one cycle");
   a_bclk_drive: assert property (settled |-> sclkOe_b == !(cfg_ff[3] && on))
      else $error("bit clock drive does not follow role and enables");
   a_ws_drive: assert property (settled |-> wsOe_b == !(cfg_ff[4] && on))
      else $error("word select drive does not follow role and enables");
   a_sd_drive: assert property (settled |-> sdOe_b == !cfg_ff[2])
      else $error("data drive does not follow transmit enable");
   a_rx_gate: assert property (rxValid && settled |-> cfg_ff[1])
      else $error("word received while receive disabled");
   a_tx_gate: assert property (txLoad && settled |-> cfg_ff[2])
      else $error("words loaded while transmit disabled");
   a_launch_edge: assert property (settled && cfg_ff[3] && !sdOe_b && $changed(sdOut) |->
      (sclkOut == cfg_ff[5] && $past(sclkOut) != cfg_ff[5]) ||
      ($past(sclkOut) == cfg_ff[5] && $past(sclkOut, 2) != cfg_ff[5]))
      else $error("data changed away from the launch edge");
   a_frame_len: assert property (txLoad && loaded_ff && settled && cfg_ff[3] |->
      rises_ff == lenTab[{cfg_ff[0], cfg_ff[26:24]}])
      else $error("frame length differs from the code");
   a_first_channel: assert property (txLoad && settled && cfg_ff[0] && cfg_ff[4] |->
      ##[1:2] wsOut == (cfg_ff[6] ^ cfg_ff[7]))
      else $error("wrong word select level for first channel");
   a_mono_sync: assert property (txLoad && settled && !cfg_ff[0] && cfg_ff[4] |-> ##[1:2] wsOut)
      else $error("mono sync not raised at word start");
endmodule // serial_audio_port_checker

bind serial_audio_port_config serial_audio_port_checker i_serial_audio_port_checker (
   .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
   .writedata(writedata), .waitrequest(waitrequest), .sclkOut(sclkOut),
   .sclkOe_b(sclkOe_b), .wsOut(wsOut), .wsOe_b(wsOe_b), .sdOut(sdOut),
   .sdOe_b(sdOe_b), .txLoad(txLoad), .rxValid(rxValid));

// file: test/audio_host_model.sv
`timescale 1ns/1ns
// ********
// Audio host on the far side of the link.
// ********
module audio_host_model
#(
   parameter int HALF_FRAME = 32
)
(
   // Control.
   input wire logic hostRun,
   // Device pins.
   input wire logic sclkOut,
   input wire logic sclkOe_b,
   input wire logic wsOut,
   input wire logic wsOe_b,
   input wire logic sdOut,
   input wire logic sdOe_b,
   // Pin levels seen by the device.
   output logic sclkIn,
   output logic wsIn,
   output logic sdIn
);
   logic hostClk = 1'b0;
   logic hostWs = 1'b0;
   logic lastSd = 1'b0;
   int slot = 0;

   // The clock stands still while hostRun is low and is offset from the system clock.
   initial
   begin
      #7;
      forever
      begin
         #80;
         if (hostRun)
            hostClk = ~hostClk;
      end
   end

   always @(negedge hostClk)
   begin
      slot = slot + 1;
      if (slot == HALF_FRAME)
      begin
         slot = 0;
         hostWs = ~hostWs;
      end
   end

   // Echo the device's data; a released line shows the inverse of its last level.
   always @*
      if (!sdOe_b)
         lastSd = sdOut;
   assign sdIn = !sdOe_b ? sdOut : ~lastSd;
   assign sclkIn = sclkOe_b ? hostClk : sclkOut;
   assign wsIn = wsOe_b ? hostWs : wsOut;
endmodule // audio_host_model

// file: test/serial_audio_port_config_test.sv
`timescale 1ns/1ns
module serial_audio_port_config_test;
   // ********
   // Bench signals.
   // ********
   localparam logic [13:0] SETUP_ADDR = 14'h1490;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [13:0] address = 14'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [23:0] txLeft = 24'h0;
   logic [23:0] txRight = 24'h0;
   logic hostRun = 1'b0;
   logic [31:0] rd;
   wire [31:0] readdata;
   wire [23:0] rxLeft, rxRight;
   wire waitrequest, sclkIn, sclkOut, sclkOe_b, wsIn, wsOut, wsOe_b, sdIn, sdOut, sdOe_b;
   wire txLoad, rxValid, rxIsRight;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   int divs[7] = '{7, 2, 63, 0, 7, 7, 7};
   int nums[7] = '{0, 0, 0, 0, 5, 1, 7};
   int dens[7] = '{0, 0, 0, 0, 0, 1, 0};
   int exps[7] = '{64, 24, 512, 16, 128, 80, 0};

   serial_audio_port_config i_serial_audio_port_config (.clock(clock), .rst_b(rst_b),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .sclkIn(sclkIn), .sclkOut(sclkOut),
      .sclkOe_b(sclkOe_b), .wsIn(wsIn), .wsOut(wsOut), .wsOe_b(wsOe_b), .sdIn(sdIn),
      .sdOut(sdOut), .sdOe_b(sdOe_b), .txLeft(txLeft), .txRight(txRight), .txLoad(txLoad),
      .rxLeft(rxLeft), .rxRight(rxRight), .rxValid(rxValid), .rxIsRight(rxIsRight));
   audio_host_model i_audio_host_model (.hostRun(hostRun), .sclkOut(sclkOut),
      .sclkOe_b(sclkOe_b), .wsOut(wsOut), .wsOe_b(wsOe_b), .sdOut(sdOut), .sdOe_b(sdOe_b),
      .sclkIn(sclkIn), .wsIn(wsIn), .sdIn(sdIn));

   initial
      forever
         #10 clock = ~clock;

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         bad_count++;
         finish_test;
      end
   end

   // ********
   // Tasks.
   // ********
   task finish_test;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check_eq(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task check_near(input int got, input int exp);
      comparisons++;
      if (got > exp + 2 || got < exp - 2)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The request stands until waitrequest is sampled low; that edge also takes read data.
   task bus_cycle(input logic wr, input logic [13:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (waitrequest !== 1'b0 && k < 20);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      check_eq(k < 20, 1);
   endtask

   task measure(output int cyc);
      logic last;
      int r;
      int k;
      last = sclkOut;
      r = 0;
      k = 0;
      cyc = 0;
      while (r < 9 && k < 1200)
      begin
         @(posedge clock);
         k++;
         if (sclkOut === 1'b1 && last === 1'b0)
            r++;
         if (r > 0)
            cyc++;
         last = sclkOut;
      end
      if (r < 9)
         cyc = 0;
   endtask

   task sync_width(output int w);
      logic lc;
      int k;
      w = 0;
      k = 0;
      while (wsOut !== 1'b0 && k < 999)
      begin
         @(posedge clock);
         k++;
      end
      while (wsOut !== 1'b1 && k < 999)
      begin
         @(posedge clock);
         k++;
      end
      lc = sclkOut;
      while (wsOut === 1'b1 && k < 999)
      begin
         @(posedge clock);
         k++;
         if (sclkOut === 1'b1 && lc === 1'b0 && wsOut === 1'b1)
            w++;
         lc = sclkOut;
      end
   endtask

   // Words sent out come back through the host's echo and must land intact under the given mask.
   task loop_run(input logic [31:0] cfg, input logic [23:0] l, input logic [23:0] r,
      input logic [23:0] mask);
      int k;
      int got;
      logic prev;
      txLeft <= l;
      txRight <= r;
      bus_cycle(1'b1, SETUP_ADDR, cfg);
      k = 0;
      got = 0;
      prev = 1'b0;
      while (got < 5 && k < 5000)
      begin
         @(posedge clock);
         k++;
         if (rxValid === 1'b1)
         begin
            if (got > 1)
               check_eq(rxIsRight, cfg[0] & ~prev);
            prev = rxIsRight;
            got++;
         end
      end
      check_eq(k < 5000, 1);
      check_eq(rxLeft, l & mask);
      if (cfg[0])
         check_eq(rxRight, r & mask);
      $display("Test link %h done", cfg);
   endtask

   // ********
   // Test sequence.
   // ********
   initial
   begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      bus_cycle(1'b0, SETUP_ADDR, 32'h0);
      check_eq(rd, 32'h0);
      bus_cycle(1'b1, SETUP_ADDR, 32'hFFFFFFFF);
      bus_cycle(1'b0, SETUP_ADDR, 32'h0);
      check_eq(rd, 32'h3F0F3FFF);
      bus_cycle(1'b0, 14'h0000, 32'h0);
      check_eq(rd, 32'h0);
      $display("Test registers done");
      for (int i = 0; i < 7; i++)
      begin
         bus_cycle(1'b1, SETUP_ADDR, {5'h0, 3'h7, 4'h0, dens[i][0], nums[i][2:0], 2'h0,
            divs[i][5:0], 8'h1D});
         repeat (20) @(posedge clock);
         measure(n);
         check_near(n, exps[i]);
      end
      $display("Test clock rates done");
      loop_run(32'h0700071F, 24'hA5C3E1, 24'h5A3C1E, 24'hFFFFFF);
      loop_run(32'h070007FF, 24'h123456, 24'h654321, 24'hFFFFFF);
      loop_run(32'h0700075F, 24'h0F0F33, 24'hF0F0CC, 24'hFFFFFF);
      loop_run(32'h1F00071E, 24'h0F1E2D, 24'h000000, 24'hFFFFFF);
      sync_width(n);
      check_eq(n, 32'h7);
      bus_cycle(1'b1, 14'h1494, 32'h7);
      bus_cycle(1'b0, 14'h1494, 32'h0);
      check_eq(rd, 32'h7);
      loop_run(32'h0700071F, 24'hC3A5E1, 24'h3C5A1E, 24'hFF0000);
      bus_cycle(1'b1, 14'h1494, 32'h0);
      hostRun <= 1'b1;
      loop_run(32'h07000707, 24'h9ABCDE, 24'h13579B, 24'hFFFFFF);
      check_eq({sclkOe_b, wsOe_b}, 2'b11);
      hostRun <= 1'b0;
      bus_cycle(1'b1, SETUP_ADDR, 32'h07000718);
      repeat (50) @(posedge clock);
      check_eq({sclkOe_b, wsOe_b, sdOe_b}, 3'b111);
      $display("Test disable done");
      finish_test;
   end
endmodule // serial_audio_port_config_test
